/* File: src/lbm_pkg.sv */
// lbm_pkg: constants for the leaky bucket activity monitor
// assumes: registers are written through a simple byte-wide register port
package lbm_pkg;
   localparam logic [7:0] LBM_ADDR_SET_LIMIT   = 8'h50;
   localparam logic [7:0] LBM_ADDR_CLEAR_LIMIT = 8'h51;
   localparam logic [7:0] LBM_ADDR_MAX_LIMIT   = 8'h52;
   localparam logic [7:0] LBM_ADDR_LEAK_RATE   = 8'h53;
   localparam logic [7:0] LBM_ADDR_STATUS      = 8'h54;
   localparam logic [7:0] LBM_RST_SET_LIMIT    = 8'h06;
   localparam logic [7:0] LBM_RST_CLEAR_LIMIT  = 8'h00;
   localparam logic [7:0] LBM_RST_MAX_LIMIT    = 8'h08;
   localparam logic [1:0] LBM_RST_LEAK_RATE    = 2'h1;
   localparam int         LBM_LEAK_LSB         = 0;
   localparam int         LBM_STAT_ALARM_BIT   = 0;
   localparam int         LBM_CYCLE_MS         = 128;
   localparam int         LBM_CLK_KHZ          = 125000;
   localparam int         LBM_CYCLE_CLKS       = LBM_CYCLE_MS * LBM_CLK_KHZ;
endpackage

/* File: src/lbm_leak_timer.sv */
// lbm_leak_timer: counts clean cycles and pulses when a leak period completes
// assumes: cycle_tick is a one-clock enable from the timebase
`timescale 1ns/1ps
module lbm_leak_timer
   import lbm_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       cycle_tick,
   input  wire logic       bad_cycle,
   input  wire logic [1:0] leak_rate,
   output logic            leak_pulse
);
   logic [2:0] clean_q;
   logic [2:0] period_m1;

   // code n gives a period of 2^n cycles
   always_comb begin
      case (leak_rate)
         2'h0:    period_m1 = 3'h0;
         2'h1:    period_m1 = 3'h1;
         2'h2:    period_m1 = 3'h3;
         default: period_m1 = 3'h7;
      endcase
   end

   // any bad cycle restarts the run of clean cycles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clean_q <= 3'h0;
      end else if (cycle_tick) begin
         if (bad_cycle || clean_q >= period_m1) begin // [R2]
            clean_q <= 3'h0;
         end else begin
            clean_q <= clean_q + 3'h1;
         end
      end
   end

   assign leak_pulse = cycle_tick && !bad_cycle && (clean_q >= period_m1); // [R2] [R7]
endmodule

/* File: src/lbm_monitor.sv */
// lbm_monitor: leaky bucket accumulator with inactivity alarm hysteresis
// assumes: fail_raw comes from the activity detector, possibly another domain;
// the 128 ms tick is generated here from core_clk
//
// Overview of operation
// [R1] once every 128 ms cycle the count goes up by one if that cycle saw a failed or erratic input.
// [R2] the count goes down by one after each run of 1, 2, 4 or 8 clean cycles chosen by the leak rate.
// [R3] when the count falls to the clear limit the inactivity alarm is cleared.
// [R4] a bad cycle never leaves the count above the max limit, which resets to eight: increments at it are dropped and a higher count is clamped to it.
// [R5] the clear limit is an eight bit read/write register at address 51 hex.
// [R6] when the count reaches the set limit, which resets to six, the alarm is raised.
// [R7] leak rate codes 00 to 11 give one decrement per 128, 256, 512 or 1024 ms, resetting to 01.
// [R8] between the limits the alarm holds, and the count never goes below zero.
`timescale 1ns/1ps
module lbm_monitor
   import lbm_pkg::*;
#(
   parameter int CYCLE_CLKS = LBM_CYCLE_CLKS
)
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       fail_raw,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic      [7:0] bucket_count,
   output logic            alarm,
   output logic            cycle_tick
);
   // a cycle shorter than two clocks would leave the tick stuck high
   if (CYCLE_CLKS < 2) begin : g_cycle_check
      $error("CYCLE_CLKS must be at least 2");
   end

   logic [31:0] tick_cnt_q;
   logic        fail_s1_q;
   logic        fail_s2_q;
   logic        bad_seen_q;
   logic [7:0]  set_limit_q;
   logic [7:0]  clear_limit_q;
   logic [7:0]  max_limit_q;
   logic [1:0]  leak_rate_q;
   logic [7:0]  count_q;
   logic [7:0]  count_d;
   logic        alarm_q;
   logic        bad_cycle;
   logic        leak_pulse;

   ////////////////////////////////////////////////////////////////////////
   // timebase and fail capture
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= 32'h0;
      end else if (tick_cnt_q == 32'(CYCLE_CLKS - 1)) begin
         tick_cnt_q <= 32'h0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
      end
   end
   assign cycle_tick = (tick_cnt_q == 32'(CYCLE_CLKS - 1)); // [R1]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fail_s1_q <= 1'b0;
         fail_s2_q <= 1'b0;
      end else begin
         fail_s1_q <= fail_raw;
         fail_s2_q <= fail_s1_q;
      end
   end

   // a failure anywhere in the cycle marks the whole cycle bad
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bad_seen_q <= 1'b0;
      end else if (cycle_tick) begin
         bad_seen_q <= 1'b0;
      end else if (fail_s2_q) begin
         bad_seen_q <= 1'b1;
      end
   end
   assign bad_cycle = bad_seen_q || fail_s2_q;

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         set_limit_q   <= LBM_RST_SET_LIMIT;
         clear_limit_q <= LBM_RST_CLEAR_LIMIT;
         max_limit_q   <= LBM_RST_MAX_LIMIT;
         leak_rate_q   <= LBM_RST_LEAK_RATE;
      end else if (reg_wr) begin
         case (reg_addr)
            LBM_ADDR_SET_LIMIT:   set_limit_q   <= reg_wdata; // [R6]
            LBM_ADDR_CLEAR_LIMIT: clear_limit_q <= reg_wdata; // [R5]
            LBM_ADDR_MAX_LIMIT:   max_limit_q   <= reg_wdata; // [R4]
            LBM_ADDR_LEAK_RATE:   leak_rate_q   <= reg_wdata[LBM_LEAK_LSB +: 2]; // [R7]
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            LBM_ADDR_SET_LIMIT:   reg_rdata <= set_limit_q;
            LBM_ADDR_CLEAR_LIMIT: reg_rdata <= clear_limit_q; // [R5]
            LBM_ADDR_MAX_LIMIT:   reg_rdata <= max_limit_q;
            LBM_ADDR_LEAK_RATE:   reg_rdata <= {6'h00, leak_rate_q};
            LBM_ADDR_STATUS:      reg_rdata <= {7'h00, alarm_q};
            default:              reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // accumulator and alarm
   lbm_leak_timer u_leak (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .cycle_tick (cycle_tick),
      .bad_cycle  (bad_cycle),
      .leak_rate  (leak_rate_q),
      .leak_pulse (leak_pulse)
   );

   always_comb begin
      count_d = count_q;
      if (cycle_tick && bad_cycle) begin
         if (count_q < max_limit_q) begin // [R4]
            count_d = count_q + 8'h01; // [R1]
         end else begin
            count_d = max_limit_q; // [R4]
         end
      end else if (leak_pulse && count_q != 8'h00) begin // [R8]
         count_d = count_q - 8'h01; // [R2]
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 8'h00;
      end else begin
         count_q <= count_d;
      end
   end

   // set is checked first so a set limit at or below the clear limit still alarms
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_q <= 1'b0;
      end else if (count_d != count_q) begin
         if (count_d >= set_limit_q) begin
            alarm_q <= 1'b1; // [R6]
         end else if (count_d <= clear_limit_q) begin
            alarm_q <= 1'b0; // [R3]
         end
      end // [R8]
   end

   assign bucket_count = count_q;
   assign alarm        = alarm_q;
endmodule

/* File: dv/lbm_monitor_assertions.sv */
// checker for the leaky bucket monitor, bound to its top ports
// assumes one clock and that limits change only through reg_wr
`timescale 1ns/1ps
module lbm_monitor_chk
   import lbm_pkg::*;
#(
   parameter int CYCLE_CLKS = LBM_CYCLE_CLKS
)
(
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       fail_raw,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] bucket_count,
   input wire logic       alarm,
   input wire logic       cycle_tick
);
   // shadow limits: thresholds can only be judged if we track the writes ourselves
   logic [7:0] set_q, clr_q, max_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         set_q <= LBM_RST_SET_LIMIT;
         clr_q <= LBM_RST_CLEAR_LIMIT;
         max_q <= LBM_RST_MAX_LIMIT;
      end else if (reg_wr) begin
         if (reg_addr == LBM_ADDR_SET_LIMIT) set_q <= reg_wdata;
         if (reg_addr == LBM_ADDR_CLEAR_LIMIT) clr_q <= reg_wdata;
         if (reg_addr == LBM_ADDR_MAX_LIMIT) max_q <= reg_wdata;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_count_off_tick: assert property (!cycle_tick |=> $stable(bucket_count)) else $error("count moved");
   a_tick_gap: assert property (cycle_tick |=> !cycle_tick [*8]) else $error("tick too close");
   a_no_wrap: assert property (bucket_count == 8'h00 && cycle_tick |=> bucket_count <= 8'h01)
      else $error("count wrapped");
   a_max_kept: assert property (bucket_count > $past(bucket_count) |-> bucket_count <= max_q)
      else $error("count over max");
   a_alarm_cause: assert property ($changed(alarm) |-> $changed(bucket_count)) else $error("alarm moved");
   a_alarm_set: assert property ($changed(bucket_count) && bucket_count >= set_q |-> alarm)
      else $error("alarm not set");
   a_alarm_clear: assert property ($changed(bucket_count) && bucket_count < set_q && bucket_count <= clr_q
      |-> !alarm) else $error("alarm not cleared");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule
////////////////////////////////////////
bind lbm_monitor lbm_monitor_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .fail_raw(fail_raw), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .bucket_count(bucket_count), .alarm(alarm), .cycle_tick(cycle_tick));

/* File: dv/lbm_monitor_tb.sv */
// bench for the leaky bucket monitor: registers, fill, leak and alarm
// assumes a 20-clock cycle; read data is checked from a queue of notes
`timescale 1ns/1ps
module lbm_monitor_tb;
   import lbm_pkg::*;
   localparam int CYC = 20;
   logic       core_clk = 0, rst_n = 0, fail_raw = 0, reg_wr = 0, reg_rd = 0, rd_q = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, bucket_count, e, q[$];
   logic       alarm, cycle_tick;
   int         err_count = 0, cmp_count = 0, cyc = 0, seed = 55392, tk_at = 0;
   lbm_monitor #(.CYCLE_CLKS(CYC)) dut (.core_clk(core_clk), .rst_n(rst_n), .fail_raw(fail_raw),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .bucket_count(bucket_count), .alarm(alarm), .cycle_tick(cycle_tick));
   always #4 core_clk = ~core_clk;
   ////////////////////////////////////////
   task chk(string n, logic [7:0] s, logic [7:0] x);
      cmp_count++;
      if (s !== x) begin
         err_count++;
         $display("BAD %s exp %h saw %h", n, x, s);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(logic [7:0] a, logic [7:0] x);
      q.push_back(x);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task tk(int n);
      repeat (n) @(posedge core_clk iff cycle_tick);
      #1;
   endtask
   // mid-cycle change keeps the two-flop sync delay clear of tick edges
   task setf(logic f);
      repeat (CYC / 2) @(posedge core_clk);
      fail_raw <= f;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (rd_q) chk("rdata", reg_rdata, q.pop_front());
      rd_q <= reg_rd;
      // every tick after the first must be one full cycle after the previous one
      if (cycle_tick) begin
         if (tk_at > 0) chk("tick gap", 8'(cyc - tk_at), 8'(CYC));
         tk_at = cyc;
      end
      if (cyc == 4000) begin
         err_count++;
         give_verdict;
      end
   end
   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(LBM_ADDR_SET_LIMIT, 8'h06);
      rd(LBM_ADDR_CLEAR_LIMIT, 8'h00);
      rd(LBM_ADDR_MAX_LIMIT, 8'h08);
      rd(LBM_ADDR_LEAK_RATE, 8'h01);
      rd(8'h60, 8'h00);
      e = 8'($random(seed));
      wr(LBM_ADDR_CLEAR_LIMIT, e);
      rd(LBM_ADDR_CLEAR_LIMIT, e);
      wr(LBM_ADDR_CLEAR_LIMIT, 8'h03);
      $display("registers done");
      tk(1);
      setf(1'b1);
      tk(10);
      chk("count", bucket_count, 8'h08);
      chk("alarm", {7'h00, alarm}, 8'h01);
      rd(LBM_ADDR_STATUS, 8'h01);
      wr(LBM_ADDR_LEAK_RATE, 8'h00);
      setf(1'b0);
      tk(2);
      chk("count", bucket_count, 8'h07);
      tk(2);
      chk("alarm", {7'h00, alarm}, 8'h01);
      rd(LBM_ADDR_STATUS, 8'h01);
      tk(2);
      chk("alarm", {7'h00, alarm}, 8'h00);
      rd(LBM_ADDR_STATUS, 8'h00);
      tk(4);
      chk("count", bucket_count, 8'h00);
      $display("fill and drain done");
      e = 8'h00;
      for (int c = 0; c < 4; c++) begin
         wr(LBM_ADDR_LEAK_RATE, 8'(c));
         setf(1'b1);
         tk(1);
         setf(1'b0);
         tk(1 << c);
         chk("count", bucket_count, e + 8'h02);
         tk(1);
         chk("count", bucket_count, e + 8'h01);
         e = e + 8'h01;
      end
      $display("leak rates done");
      // count is 4 here: a lowered ceiling clamps it on the next bad cycle, and the lowered set limit alarms there
      wr(LBM_ADDR_MAX_LIMIT, 8'h02);
      wr(LBM_ADDR_SET_LIMIT, 8'h02);
      rd(LBM_ADDR_MAX_LIMIT, 8'h02);
      setf(1'b1);
      tk(2);
      chk("count", bucket_count, 8'h02);
      chk("alarm", {7'h00, alarm}, 8'h01);
      setf(1'b0);
      repeat (3) @(posedge core_clk);
      $display("ceiling done");
      give_verdict;
   end
endmodule
